/* File: rtl/btc_pkg.sv */
`default_nettype none
package btc_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0]  BTC_ADDR_BRIDGE   = 8'h3e;
    localparam logic [7:0]  BTC_ADDR_CHIP     = 8'h40;
    localparam logic [7:0]  BTC_ADDR_DIAG     = 8'h41;
    localparam logic [7:0]  BTC_ADDR_IRQ_STAT = 8'h48;
    localparam logic [7:0]  BTC_ADDR_IRQ_MASK = 8'h49;

    // bridge control fields
    localparam int          BTC_BC_SEC_RESET  = 6;
    localparam int          BTC_BC_PRI_MTO    = 8;
    localparam int          BTC_BC_SEC_MTO    = 9;
    localparam int          BTC_BC_MTO_STAT   = 10;
    localparam int          BTC_BC_MTO_SERR   = 11;
    // chip control fields
    localparam int          BTC_CC_WR_DISC    = 1;
    localparam int          BTC_CC_KEEP_LO    = 2;
    localparam int          BTC_CC_KEEP_HI    = 3;
    localparam int          BTC_CC_PF_DIS     = 4;
    // diagnostic control fields
    localparam int          BTC_DC_CHIP_RST   = 0;
    localparam int          BTC_DC_TEST_LO    = 1;
    localparam int          BTC_DC_TEST_HI    = 2;
    localparam int          BTC_DC_SRST_MASK  = 3;

    // reset values
    localparam logic [15:0] BTC_BRIDGE_RST    = 16'h0000;
    localparam logic [7:0]  BTC_CHIP_RST      = 8'h00;
    localparam logic [7:0]  BTC_DIAG_RST      = 8'h00;
    localparam logic [1:0]  BTC_IRQ_RST       = 2'h0;

    // master timeouts in pci clocks
    localparam int          BTC_MTO_LONG_CLKS  = 32768;
    localparam int          BTC_MTO_SHORT_CLKS = 1024;
    localparam int          BTC_TMR_W          = 16;
    localparam int          BTC_PORTS          = 2;   // 0 upstream, 1 downstream

    // upstream memory read commands
    typedef enum logic [1:0] {
        BTC_MEM_READ      = 2'h0,
        BTC_MEM_READ_LINE = 2'h1,
        BTC_MEM_READ_MULT = 2'h2
    } btc_rdcmd_type;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } btc_req_type;

    // read/prefetch decision
    typedef struct packed {
        logic prefetch;
        logic forward_be;
        logic single_dword;
    } btc_rdpol_type;
endpackage
`default_nettype wire

/* File: rtl/btc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - upstream timeout: 2^15 or 2^10 clocks
// - downstream timeout selected the same way
// - either timeout sets sticky status, write-one clears
// - timeout error enable drives system error out
// - write disconnect also at cache lines
// - prefetch disable: one dword, forward enables
// - line and multiple reads stay prefetchable
// - chip reset sets secondary reset bit
// - chip reset bit self-clears; zero ignored
// - mask stops upstream reset reaching downstream
// - reserved upper bits read as zero
// - secondary reset bit holds reset pin
module btc_ctrl
    import btc_pkg::*;
#(
    parameter int MTO_LONG_CLKS = BTC_MTO_LONG_CLKS
) (
    // clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          reset_n_i,
    // register port
    input  wire btc_req_type   req_i,
    output var  logic [15:0]   rdata_o,
    // delayed transactions, index 0 upstream, 1 downstream
    input  wire logic [1:0]    dt_pending_i,
    input  wire logic [1:0]    dt_retry_i,
    output var  logic [1:0]    dt_discard_o,
    // memory write target
    input  wire logic          wr_queue_full_i,
    input  wire logic          wr_at_4k_i,
    input  wire logic          wr_at_cache_line_i,
    output var  logic          wr_disconnect_o,
    // upstream memory read
    input  wire logic          rd_valid_i,
    input  wire btc_rdcmd_type rd_cmd_i,
    output var  btc_rdpol_type rd_pol_o,
    // pins and chip
    input  wire logic          upstream_reset_in_n_i,
    output var  logic          upstream_system_error_out_n_o,
    output var  logic          downstream_reset_out_n_o,
    output var  logic          chip_soft_reset_o,
    output var  logic          irq_o
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BTC_CR_RUN   = 2'b01,
        BTC_CR_RESET = 2'b10
    } btc_crst_type;

    logic [15:0]         bridge, next_bridge;
    logic [7:0]          chip, next_chip;
    logic [7:0]          diag, next_diag;
    logic [1:0]          irq_stat, next_irq_stat;
    logic [1:0]          irq_mask, next_irq_mask;
    logic [15:0]         next_rdata;
    btc_crst_type        crst, next_crst;
    logic [1:0]          tmo;
    logic                next_serr_n, next_srst_n, next_irq, next_disc;
    btc_rdpol_type       next_pol;
    logic                wr_bridge, wr_chip, wr_diag, wr_stat, wr_mask;

    assign wr_bridge = req_i.wr && (req_i.addr == BTC_ADDR_BRIDGE);
    assign wr_chip   = req_i.wr && (req_i.addr == BTC_ADDR_CHIP);
    assign wr_diag   = req_i.wr && (req_i.addr == BTC_ADDR_DIAG);
    assign wr_stat   = req_i.wr && (req_i.addr == BTC_ADDR_IRQ_STAT);
    assign wr_mask   = req_i.wr && (req_i.addr == BTC_ADDR_IRQ_MASK);

    // ------------------------------------------------------------------
    // master timeout timers, one per port
    // ------------------------------------------------------------------
    for (genvar p = 0; p < BTC_PORTS; p++) begin : g_tmr
        logic [BTC_TMR_W-1:0] cnt, next_cnt, limit;
        logic                 next_tmo;
        logic                 tmo_q;
        // select bit picks the short or the long limit
        assign limit = bridge[BTC_BC_PRI_MTO + p] ?
                       BTC_TMR_W'(BTC_MTO_SHORT_CLKS - 1) :
                       BTC_TMR_W'(MTO_LONG_CLKS - 1);
        // count while a request waits for its repeat
        always_comb begin
            next_cnt = '0;
            next_tmo = 1'b0;
            if (crst == BTC_CR_RESET || !dt_pending_i[p] || dt_retry_i[p]) begin
                next_cnt = '0;
            end else if (cnt >= limit) begin
                next_tmo = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cnt   <= '0;
                tmo_q <= 1'b0;
            end else begin
                cnt   <= next_cnt;
                tmo_q <= next_tmo;
            end
        end
        assign tmo[p] = tmo_q;
        // expiry frees the buffer entry of the waiting transaction
        assign dt_discard_o[p] = tmo_q;

        // a limit lowered mid-count expires on the next edge instead of running on
        a_tmr_bound: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
            (cnt >= limit) && dt_pending_i[p] && !dt_retry_i[p] && crst == BTC_CR_RUN
            |=> tmo_q && (cnt == '0)) else $error("timer did not expire at its limit");
    end

    // ------------------------------------------------------------------
    // registers and chip reset sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_bridge   = bridge;
        next_chip     = chip;
        next_diag     = diag;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        next_crst     = crst;
        if (crst == BTC_CR_RESET) begin
            // everything returns to reset except the secondary reset bit
            next_bridge                   = BTC_BRIDGE_RST;
            next_bridge[BTC_BC_SEC_RESET] = 1'b1;
            next_chip                     = BTC_CHIP_RST;
            next_diag                     = BTC_DIAG_RST;
            next_irq_stat                 = BTC_IRQ_RST;
            next_irq_mask                 = BTC_IRQ_RST;
            next_crst                     = BTC_CR_RUN;
        end else begin
            if (wr_bridge) begin
                next_bridge[BTC_BC_SEC_RESET] = req_i.wdata[BTC_BC_SEC_RESET];
                next_bridge[BTC_BC_PRI_MTO]   = req_i.wdata[BTC_BC_PRI_MTO];
                next_bridge[BTC_BC_SEC_MTO]   = req_i.wdata[BTC_BC_SEC_MTO];
                next_bridge[BTC_BC_MTO_SERR]  = req_i.wdata[BTC_BC_MTO_SERR];
                if (req_i.wdata[BTC_BC_MTO_STAT]) begin
                    next_bridge[BTC_BC_MTO_STAT] = 1'b0;
                end
            end
            if (wr_chip) begin
                next_chip[BTC_CC_WR_DISC] = req_i.wdata[BTC_CC_WR_DISC];
                next_chip[BTC_CC_KEEP_HI:BTC_CC_KEEP_LO] =
                    req_i.wdata[BTC_CC_KEEP_HI:BTC_CC_KEEP_LO];
                next_chip[BTC_CC_PF_DIS]  = req_i.wdata[BTC_CC_PF_DIS];
            end
            if (wr_diag) begin
                next_diag[BTC_DC_TEST_HI:BTC_DC_TEST_LO] =
                    req_i.wdata[BTC_DC_TEST_HI:BTC_DC_TEST_LO];
                next_diag[BTC_DC_SRST_MASK] = req_i.wdata[BTC_DC_SRST_MASK];
                if (req_i.wdata[BTC_DC_CHIP_RST]) begin
                    next_diag[BTC_DC_CHIP_RST]    = 1'b1;
                    next_bridge[BTC_BC_SEC_RESET] = 1'b1;
                    next_crst                     = BTC_CR_RESET;
                end
            end
            if (wr_stat) begin
                next_irq_stat = irq_stat & ~req_i.wdata[1:0];
            end
            if (wr_mask) begin
                next_irq_mask = req_i.wdata[1:0];
            end
            // a timeout in the clearing cycle still sets the flags
            if (|tmo) begin
                next_bridge[BTC_BC_MTO_STAT] = 1'b1;
            end
            next_irq_stat = next_irq_stat | tmo;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bridge   <= BTC_BRIDGE_RST;
            chip     <= BTC_CHIP_RST;
            diag     <= BTC_DIAG_RST;
            irq_stat <= BTC_IRQ_RST;
            irq_mask <= BTC_IRQ_RST;
            crst     <= BTC_CR_RUN;
        end else begin
            bridge   <= next_bridge;
            chip     <= next_chip;
            diag     <= next_diag;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            crst     <= next_crst;
        end
    end

    // ------------------------------------------------------------------
    // read data and pin / policy outputs
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        if (req_i.rd) begin
            unique case (req_i.addr)
                BTC_ADDR_BRIDGE:   next_rdata = bridge;
                BTC_ADDR_CHIP:     next_rdata = {8'h00, chip};
                BTC_ADDR_DIAG:     next_rdata = {8'h00, diag};
                BTC_ADDR_IRQ_STAT: next_rdata = {14'h0000, irq_stat};
                BTC_ADDR_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
                default:           next_rdata = 16'h0000;
            endcase
        end
        next_serr_n = !(bridge[BTC_BC_MTO_SERR] && (|tmo));
        next_srst_n = !(bridge[BTC_BC_SEC_RESET] ||
                        (!upstream_reset_in_n_i && !diag[BTC_DC_SRST_MASK]));
        next_irq    = |(next_irq_stat & irq_mask);
        next_disc   = wr_queue_full_i || wr_at_4k_i ||
                      (chip[BTC_CC_WR_DISC] && wr_at_cache_line_i);
        next_pol    = '0;
        if (rd_valid_i) begin
            if (!chip[BTC_CC_PF_DIS] || rd_cmd_i != BTC_MEM_READ) begin
                next_pol.prefetch = 1'b1;
            end else begin
                next_pol.forward_be   = 1'b1;
                next_pol.single_dword = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o                       <= 16'h0000;
            upstream_system_error_out_n_o <= 1'b1;
            downstream_reset_out_n_o      <= 1'b1;
            chip_soft_reset_o             <= 1'b0;
            irq_o                         <= 1'b0;
            wr_disconnect_o               <= 1'b0;
            rd_pol_o                      <= '0;
        end else begin
            rdata_o                       <= next_rdata;
            upstream_system_error_out_n_o <= next_serr_n;
            downstream_reset_out_n_o      <= next_srst_n;
            chip_soft_reset_o             <= (next_crst == BTC_CR_RESET);
            irq_o                         <= next_irq;
            wr_disconnect_o               <= next_disc;
            rd_pol_o                      <= next_pol;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_mto_status_set: assert property ((|tmo) |=> bridge[BTC_BC_MTO_STAT])
        else $error("timeout did not set status");
    a_serr_on_tmo: assert property ((|tmo) && bridge[BTC_BC_MTO_SERR]
        |=> !upstream_system_error_out_n_o) else $error("system error missing");
    a_serr_quiet: assert property (!bridge[BTC_BC_MTO_SERR]
        |=> upstream_system_error_out_n_o) else $error("system error while disabled");
    a_chip_rst_seq: assert property (wr_diag && req_i.wdata[BTC_DC_CHIP_RST] &&
        crst == BTC_CR_RUN |=> diag[BTC_DC_CHIP_RST] && bridge[BTC_BC_SEC_RESET]
        ##1 !diag[BTC_DC_CHIP_RST] && bridge[BTC_BC_SEC_RESET])
        else $error("chip reset sequence wrong");
    a_chip_rst_zero: assert property (wr_diag && !req_i.wdata[BTC_DC_CHIP_RST] &&
        crst == BTC_CR_RUN |=> crst == BTC_CR_RUN) else $error("zero write reset chip");
    a_srst_hold: assert property (bridge[BTC_BC_SEC_RESET]
        |=> !downstream_reset_out_n_o) else $error("reset pin not held");
    a_srst_mask: assert property (diag[BTC_DC_SRST_MASK] &&
        !bridge[BTC_BC_SEC_RESET] |=> downstream_reset_out_n_o)
        else $error("masked reset reached pin");
    a_rsvd_zero: assert property (req_i.rd && req_i.addr == BTC_ADDR_CHIP
        |=> rdata_o[15:BTC_CC_PF_DIS+1] == '0 && !rdata_o[0])
        else $error("reserved chip bits not zero");
    a_rsvd_diag: assert property (req_i.rd && req_i.addr == BTC_ADDR_DIAG
        |=> rdata_o[15:BTC_DC_SRST_MASK+1] == '0) else $error("reserved diag bits not zero");
    a_cache_disc: assert property (chip[BTC_CC_WR_DISC] && wr_at_cache_line_i
        |=> wr_disconnect_o) else $error("no cache line disconnect");
    a_single_dword: assert property (rd_valid_i && chip[BTC_CC_PF_DIS] &&
        rd_cmd_i == BTC_MEM_READ |=> rd_pol_o.single_dword && !rd_pol_o.prefetch)
        else $error("prefetch not disabled");
    a_line_prefetch: assert property (rd_valid_i && rd_cmd_i != BTC_MEM_READ
        |=> rd_pol_o.prefetch) else $error("line read not prefetched");

    c_timeout:   cover property (|tmo ##1 !upstream_system_error_out_n_o);
    c_chip_rst:  cover property (crst == BTC_CR_RESET);
    c_pf_single: cover property (rd_pol_o.single_dword);
    c_irq:       cover property (irq_o);
endmodule // btc_ctrl
`default_nettype wire

/* File: dv/btc_pci_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module btc_pci_peer (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // bench commands
    input  wire logic [1:0] start_i,
    input  wire logic [1:0] repeat_i,
    // bridge side
    input  wire logic [1:0] dt_discard_i,
    output logic [1:0]      dt_pending_o,
    output logic [1:0]      dt_retry_o
);
    logic [1:0] next_pending;
    logic [1:0] next_retry;

    // request waits until discarded; repeats only while waiting
    always_comb begin
        next_pending = (dt_pending_o | start_i) & ~dt_discard_i;
        next_retry   = repeat_i & dt_pending_o;
    end

    // initiator state
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dt_pending_o <= 2'h0;
            dt_retry_o   <= 2'h0;
        end else begin
            dt_pending_o <= next_pending;
            dt_retry_o   <= next_retry;
        end
    end
endmodule // btc_pci_peer
`default_nettype wire

/* File: dv/btc_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module btc_ctrl_tb_top
    import btc_pkg::*;
;
    // ------------------------------------------------------------
    // policy rows: chip reg, {full,4k,line}, read cmd, expectations
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    cc;
        logic [2:0]    wq;
        btc_rdcmd_type cmd;
        logic          disc;
        btc_rdpol_type pol;
    } btc_row_type;
    localparam int LONG = 64;
    localparam btc_row_type ROWS [8] = '{
        '{8'h00, 3'h4, BTC_MEM_READ,      1'b1, 3'h4},
        '{8'h00, 3'h2, BTC_MEM_READ_LINE, 1'b1, 3'h4},
        '{8'h00, 3'h1, BTC_MEM_READ_MULT, 1'b0, 3'h4},
        '{8'h02, 3'h1, BTC_MEM_READ,      1'b1, 3'h4},
        '{8'h12, 3'h1, BTC_MEM_READ,      1'b1, 3'h3},
        '{8'h12, 3'h0, BTC_MEM_READ_LINE, 1'b0, 3'h4},
        '{8'h12, 3'h4, BTC_MEM_READ_MULT, 1'b1, 3'h4},
        '{8'h10, 3'h0, BTC_MEM_READ,      1'b0, 3'h3}};

    logic          clk_sys_i = 1'b0;
    logic          reset_n_i = 1'b0;
    btc_req_type   req_i     = '0;
    logic [15:0]   rdata_o;
    logic [1:0]    pend, retry, disc;
    logic [1:0]    start     = 2'h0;
    logic [1:0]    rep       = 2'h0;
    logic [2:0]    wq        = 3'h0;
    logic          rd_valid  = 1'b0;
    btc_rdcmd_type rd_cmd    = BTC_MEM_READ;
    btc_rdpol_type rd_pol;
    logic          up_rst_n  = 1'b1;
    logic          serr_n, srst_n, soft_rst, irq, wr_disc;
    int            fails     = 0;
    int            n_tests   = 0;

    // 10 MHz clock
    always #50 clk_sys_i = ~clk_sys_i;

    btc_ctrl #(.MTO_LONG_CLKS(LONG)) uut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i),
        .rdata_o(rdata_o), .dt_pending_i(pend), .dt_retry_i(retry),
        .dt_discard_o(disc), .wr_queue_full_i(wq[2]), .wr_at_4k_i(wq[1]),
        .wr_at_cache_line_i(wq[0]), .wr_disconnect_o(wr_disc),
        .rd_valid_i(rd_valid), .rd_cmd_i(rd_cmd), .rd_pol_o(rd_pol),
        .upstream_reset_in_n_i(up_rst_n),
        .upstream_system_error_out_n_o(serr_n),
        .downstream_reset_out_n_o(srst_n), .chip_soft_reset_o(soft_rst),
        .irq_o(irq));

    btc_pci_peer peer (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start),
        .repeat_i(rep), .dt_discard_i(disc), .dt_pending_o(pend),
        .dt_retry_o(retry));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one-cycle write strobe; returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        req_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        req_i <= '0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        req_i <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        req_i <= '0;
        #1 chk("rdata", e, rdata_o);
    endtask

    // start a delayed request, optionally repeat it, count to discard
    task automatic tmo(input int p, input int lim, input logic en, input logic rt);
        int c;
        c = 0;
        @(posedge clk_sys_i);
        start[p] <= 1'b1;
        @(posedge clk_sys_i);
        start[p] <= 1'b0;
        if (rt) begin
            repeat (30) @(posedge clk_sys_i);
            rep[p] <= 1'b1;
            @(posedge clk_sys_i);
            rep[p] <= 1'b0;
        end
        #1;
        while (disc[p] !== 1'b1 && c < 40000) begin
            @(posedge clk_sys_i);
            #1 c++;
        end
        chk("mto_clocks", 16'h0001, 16'(c >= lim - 2 && c <= lim + 2));
        @(posedge clk_sys_i);
        #1 chk("serr_n", 16'(!en), 16'(serr_n));
    endtask

    task automatic results;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        #(10000 * 100);
        fails++;
        results;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd(BTC_ADDR_BRIDGE, 16'h0000);
        rd(BTC_ADDR_CHIP, 16'h0000);
        rd(BTC_ADDR_DIAG, 16'h0000);
        chk("srst_n", 16'h0001, 16'(srst_n));
        for (int i = 0; i < 8; i++) begin
            wr(BTC_ADDR_CHIP, {8'h00, ROWS[i].cc});
            @(posedge clk_sys_i);
            wq       <= ROWS[i].wq;
            rd_cmd   <= ROWS[i].cmd;
            rd_valid <= 1'b1;
            @(posedge clk_sys_i);
            wq       <= 3'h0;
            rd_valid <= 1'b0;
            #1 chk("disconnect", 16'(ROWS[i].disc), 16'(wr_disc));
            chk("rd_pol", 16'(ROWS[i].pol), 16'(rd_pol));
        end
        // reserved bits and unmapped address; bits two, three kept zero
        wr(BTC_ADDR_CHIP, 16'hfff3);
        rd(BTC_ADDR_CHIP, 16'h0012);
        wr(BTC_ADDR_DIAG, 16'hfff6);
        rd(BTC_ADDR_DIAG, 16'h0006);
        wr(8'h50, 16'hffff);
        rd(8'h50, 16'h0000);
        // upstream short with error out, unmasked interrupt
        wr(BTC_ADDR_IRQ_MASK, 16'h0001);
        wr(BTC_ADDR_BRIDGE, 16'h0900);
        tmo(0, 1024, 1'b1, 1'b0);
        rd(BTC_ADDR_BRIDGE, 16'h0d00);
        chk("irq", 16'h0001, 16'(irq));
        rd(BTC_ADDR_IRQ_STAT, 16'h0001);
        wr(BTC_ADDR_IRQ_STAT, 16'h0001);
        wr(BTC_ADDR_BRIDGE, 16'h0d00);
        rd(BTC_ADDR_BRIDGE, 16'h0900);
        chk("irq", 16'h0000, 16'(irq));
        // downstream long with a repeat, error out disabled, masked
        wr(BTC_ADDR_BRIDGE, 16'h0100);
        tmo(1, LONG, 1'b0, 1'b1);
        rd(BTC_ADDR_BRIDGE, 16'h0500);
        rd(BTC_ADDR_IRQ_STAT, 16'h0002);
        chk("irq", 16'h0000, 16'(irq));
        wr(BTC_ADDR_BRIDGE, 16'h0600);
        tmo(0, LONG, 1'b0, 1'b0);
        tmo(1, 1024, 1'b0, 1'b0);
        // upstream reset pin with and without the mask
        for (int m = 0; m < 2; m++) begin
            wr(BTC_ADDR_DIAG, 16'(m * 8));
            @(posedge clk_sys_i);
            up_rst_n <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            #1 chk("srst_n", 16'(m), 16'(srst_n));
            @(posedge clk_sys_i);
            up_rst_n <= 1'b1;
            repeat (2) @(posedge clk_sys_i);
        end
        // software chip reset
        wr(BTC_ADDR_BRIDGE, 16'h0b00);
        wr(BTC_ADDR_CHIP, 16'h0012);
        wr(BTC_ADDR_DIAG, 16'h0001);
        chk("soft_rst", 16'h0001, 16'(soft_rst));
        @(posedge clk_sys_i);
        #1 chk("srst_n", 16'h0000, 16'(srst_n));
        rd(BTC_ADDR_BRIDGE, 16'h0040);
        rd(BTC_ADDR_CHIP, 16'h0000);
        rd(BTC_ADDR_DIAG, 16'h0000);
        wr(BTC_ADDR_DIAG, 16'h0000);
        rd(BTC_ADDR_BRIDGE, 16'h0040);
        wr(BTC_ADDR_BRIDGE, 16'h0000);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("srst_n", 16'h0001, 16'(srst_n));
        results;
    end
endmodule // btc_ctrl_tb_top
`default_nettype wire
